// *** slave_watchdog_and_state_machine.sv ***
// Process data and local port watchdogs, safe output control and operating state machine
`include "slave_wd_defines.svh"

module slave_watchdog_and_state_machine
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData_q,
    input  wire logic        stateReqValid,
    input  wire logic [2:0]  stateReqCode,
    input  wire logic        mailboxSetupOk,
    input  wire logic        syncSetupOk,
    input  wire logic        pdAccess,
    input  wire logic        localAccess,
    input  wire logic [15:0] masterOutData,
    input  wire logic [15:0] procInData,
    output logic      [15:0] outData_q,
    output logic      [15:0] inputSnap_q,
    output logic             inputCopy_q,
    output logic             stateAck_q,
    output logic             stateRefuse_q,
    output logic      [4:0]  curState_q,
    output logic             mbxAllowed_q,
    output logic             pdAllowed_q,
    output logic             fileOnly_q,
    output logic             pdExpired_q,
    output logic             lpExpired_q
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [15:0]           presc_q;
    logic [15:0]           lpTime_q;
    logic [15:0]           pdTime_q;
    logic [15:0]           safeVal_q;
    slave_wd_pkg::op_state_t stateQ;
    slave_wd_pkg::op_state_t stateD;

    // Register writes from the master side, full 16-bit counts
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            presc_q   <= `PRESCALER_RST;
            lpTime_q  <= `LOCAL_TIME_RST;
            pdTime_q  <= `PD_TIME_RST;
            safeVal_q <= `SAFE_VALUE_RST;
        end
        else if (regWr)
        begin
            if (regAddr == `REG_PRESCALER)
                presc_q <= regWrData;
            else if (regAddr == `REG_LOCAL_TIME)
                lpTime_q <= regWrData;
            else if (regAddr == `REG_PD_TIME)
                pdTime_q <= regWrData;
            else if (regAddr == `REG_SAFE_VALUE)
                safeVal_q <= regWrData;
        end
    end

    // Read port, one cycle latency, unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (srst)
            regRdData_q <= 16'h0000;
        else if (regRd)
        begin
            if (regAddr == `REG_PRESCALER)
                regRdData_q <= presc_q;
            else if (regAddr == `REG_LOCAL_TIME)
                regRdData_q <= lpTime_q;
            else if (regAddr == `REG_PD_TIME)
                regRdData_q <= pdTime_q;
            else if (regAddr == `REG_SAFE_VALUE)
                regRdData_q <= safeVal_q;
            else if (regAddr == `REG_STATUS)
                regRdData_q <= {7'h00, stateQ, 2'h0,
                                lpExpired_q, pdExpired_q};
            else
                regRdData_q <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared prescaler

    logic [3:0]  baseCnt_q;
    logic        baseTick;
    logic [16:0] prescCnt_q;
    logic        wdTick;

    // 25 MHz base tick enable from the 200 MHz clock
    assign baseTick = (baseCnt_q == 4'(`BASE_DIV - 1));

    always_ff @(posedge clk)
    begin
        if (srst || baseTick)
            baseCnt_q <= 4'h0;
        else
            baseCnt_q <= baseCnt_q + 4'h1;
    end

    // One watchdog tick per prescaler plus two base ticks
    assign wdTick = baseTick
                    && (prescCnt_q >= {1'b0, presc_q} + 17'(`WD_TICK_EXTRA - 1));

    always_ff @(posedge clk)
    begin
        if (srst || wdTick)
            prescCnt_q <= 17'h00000;
        else if (baseTick)
            prescCnt_q <= prescCnt_q + 17'h00001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog timers

    logic pdKick;

    // Only accesses allowed in the current state count as successful
    assign pdKick = pdAccess && pdAllowed_q;

    // Process data watchdog, zero time disables
    wd_timer u_pd_wd
    (
        .clk       (clk),
        .srst      (srst),
        .wdTick    (wdTick),
        .kick      (pdKick),
        .timeVal   (pdTime_q),
        .expired_q (pdExpired_q)
    );

    // Local port watchdog
    wd_timer u_lp_wd
    (
        .clk       (clk),
        .srst      (srst),
        .wdTick    (wdTick),
        .kick      (localAccess),
        .timeVal   (lpTime_q),
        .expired_q (lpExpired_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // State machine

    logic reqOk;

    // Next state from a request; refused requests keep the state
    always_comb
    begin
        stateD = stateQ;
        reqOk  = 1'b0;
        if (stateReqValid)
        begin
            case (stateReqCode)
                slave_wd_pkg::REQ_POWERUP:
                begin
                    stateD = slave_wd_pkg::ST_POWERUP;
                    reqOk  = 1'b1;
                end
                slave_wd_pkg::REQ_PRECONFIG:
                    if (stateQ != slave_wd_pkg::ST_FW_LOAD && mailboxSetupOk)
                    begin
                        stateD = slave_wd_pkg::ST_PRECONFIG;
                        reqOk  = 1'b1;
                    end
                slave_wd_pkg::REQ_SAFE_RUN:
                    if ((stateQ == slave_wd_pkg::ST_PRECONFIG && syncSetupOk)
                        || stateQ == slave_wd_pkg::ST_SAFE_RUN
                        || stateQ == slave_wd_pkg::ST_RUNNING)
                    begin
                        stateD = slave_wd_pkg::ST_SAFE_RUN;
                        reqOk  = 1'b1;
                    end
                slave_wd_pkg::REQ_RUNNING:
                    if (stateQ == slave_wd_pkg::ST_SAFE_RUN
                        || stateQ == slave_wd_pkg::ST_RUNNING)
                    begin
                        stateD = slave_wd_pkg::ST_RUNNING;
                        reqOk  = 1'b1;
                    end
                slave_wd_pkg::REQ_FW_LOAD:
                    if (stateQ == slave_wd_pkg::ST_POWERUP
                        || stateQ == slave_wd_pkg::ST_FW_LOAD)
                    begin
                        stateD = slave_wd_pkg::ST_FW_LOAD;
                        reqOk  = 1'b1;
                    end
                default:
                    reqOk = 1'b0;
            endcase
        end
    end

    // State register; watchdog expiry never moves it
    always_ff @(posedge clk)
    begin
        if (srst)
            stateQ <= slave_wd_pkg::ST_POWERUP;
        else
            stateQ <= stateD;
    end

    // Acknowledge or refuse each request
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stateAck_q    <= 1'b0;
            stateRefuse_q <= 1'b0;
            curState_q    <= 5'h01;
        end
        else
        begin
            stateAck_q    <= stateReqValid && reqOk;
            stateRefuse_q <= stateReqValid && !reqOk;
            curState_q    <= stateD;
        end
    end

    // Traffic permission per state, aligned with the state register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mbxAllowed_q <= 1'b0;
            pdAllowed_q  <= 1'b0;
            fileOnly_q   <= 1'b0;
        end
        else
        begin
            mbxAllowed_q <= (stateD != slave_wd_pkg::ST_POWERUP);
            pdAllowed_q  <= (stateD == slave_wd_pkg::ST_SAFE_RUN)
                            || (stateD == slave_wd_pkg::ST_RUNNING);
            fileOnly_q   <= (stateD == slave_wd_pkg::ST_FW_LOAD);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Process data paths

    logic enterSafe;

    assign enterSafe = (stateQ == slave_wd_pkg::ST_PRECONFIG)
                       && (stateD == slave_wd_pkg::ST_SAFE_RUN);

    // Input snapshot on safe-run entry, then cyclic updates
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            inputSnap_q <= 16'h0000;
            inputCopy_q <= 1'b0;
        end
        else
        begin
            inputCopy_q <= enterSafe;
            if (enterSafe || pdAllowed_q)
                inputSnap_q <= procInData;
        end
    end

    // Outputs follow the master only while running and no watchdog fired
    always_ff @(posedge clk)
    begin
        if (srst)
            outData_q <= `SAFE_VALUE_RST;
        else if (stateQ == slave_wd_pkg::ST_RUNNING && !pdExpired_q && !lpExpired_q)
            outData_q <= masterOutData;
        else
            outData_q <= safeVal_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_reset_defaults: assert property (@(posedge clk)
        $fell(srst) |-> presc_q == 16'h09C2 && pdTime_q == 16'h03E8)
        else $error("prescaler or timer default wrong");

    chk_tick_spacing: assert property (@(posedge clk) disable iff (srst)
        wdTick |=> !wdTick [*8])
        else $error("watchdog ticks too close");

    chk_state_kept: assert property (@(posedge clk) disable iff (srst)
        $rose(pdExpired_q) |-> stateQ == $past(stateQ) || $past(stateReqValid))
        else $error("state moved on watchdog expiry");

    chk_expiry_clear: assert property (@(posedge clk) disable iff (srst)
        $fell(pdExpired_q) |-> $past(pdKick) || $past(pdTime_q) == 16'h0000)
        else $error("expiry cleared without access");

    chk_disable_zero: assert property (@(posedge clk) disable iff (srst)
        pdTime_q == 16'h0000 |=> !pdExpired_q)
        else $error("disabled watchdog expired");

    chk_powerup_gate: assert property (@(posedge clk) disable iff (srst)
        stateQ == slave_wd_pkg::ST_POWERUP |-> !mbxAllowed_q && !pdAllowed_q)
        else $error("traffic allowed in power-up");

    chk_fw_entry: assert property (@(posedge clk) disable iff (srst)
        stateQ == slave_wd_pkg::ST_FW_LOAD && $past(stateQ) != slave_wd_pkg::ST_FW_LOAD
        |-> $past(stateQ) == slave_wd_pkg::ST_POWERUP)
        else $error("firmware-load entered from wrong state");

    chk_fw_gate: assert property (@(posedge clk) disable iff (srst)
        stateQ == slave_wd_pkg::ST_FW_LOAD |-> fileOnly_q && !pdAllowed_q)
        else $error("wrong traffic in firmware-load");

    chk_safe_hold: assert property (@(posedge clk) disable iff (srst)
        stateQ == slave_wd_pkg::ST_SAFE_RUN |=> outData_q == $past(safeVal_q))
        else $error("outputs not safe in safe-run");

    chk_run_copy: assert property (@(posedge clk) disable iff (srst)
        stateQ == slave_wd_pkg::ST_RUNNING && !pdExpired_q && !lpExpired_q
        |=> outData_q == $past(masterOutData))
        else $error("running outputs not copied");

    chk_expired_safe: assert property (@(posedge clk) disable iff (srst)
        pdExpired_q ##1 pdExpired_q |-> outData_q == $past(safeVal_q))
        else $error("outputs not safe after expiry");

    chk_safe_copy: assert property (@(posedge clk) disable iff (srst)
        enterSafe |=> inputCopy_q && stateAck_q)
        else $error("no input copy on safe-run entry");

    cov_pd_fire: cover property (@(posedge clk) disable iff (srst) $rose(pdExpired_q));
    cov_lp_fire: cover property (@(posedge clk) disable iff (srst) $rose(lpExpired_q));
    cov_running: cover property (@(posedge clk) disable iff (srst)
        stateQ == slave_wd_pkg::ST_RUNNING);
    cov_fw_load: cover property (@(posedge clk) disable iff (srst)
        stateQ == slave_wd_pkg::ST_FW_LOAD);

endmodule

// *** slave_wd_defines.svh ***
// Register offsets, reset values and timing counts for the watchdog block
`ifndef SLAVE_WD_DEFINES_SVH
`define SLAVE_WD_DEFINES_SVH

// Register offsets
`define REG_PRESCALER    16'h0400
`define REG_LOCAL_TIME   16'h0410
`define REG_PD_TIME      16'h0420
`define REG_SAFE_VALUE   16'h0430
`define REG_STATUS       16'h0440

// Reset values
`define PRESCALER_RST    16'h09C2
`define LOCAL_TIME_RST   16'h03E8
`define PD_TIME_RST      16'h03E8
`define SAFE_VALUE_RST   16'h0000

// Status register field positions
`define ST_PD_EXP_BIT    0
`define ST_LP_EXP_BIT    1
`define ST_STATE_LSB     4
`define ST_STATE_MSB     8

// Timing: base tick of 40 ns derived from the 5 ns clock
`define CLK_PERIOD_NS    5
`define BASE_TICK_NS     40
`define BASE_DIV         (`BASE_TICK_NS / `CLK_PERIOD_NS)
`define WD_TICK_EXTRA    2

`endif

// *** slave_wd_pkg.sv ***
// Types shared by the watchdog and state machine block
package slave_wd_pkg;

    // Operating states, one-hot
    typedef enum logic [4:0] {
        ST_POWERUP   = 5'h01,
        ST_PRECONFIG = 5'h02,
        ST_SAFE_RUN  = 5'h04,
        ST_RUNNING   = 5'h08,
        ST_FW_LOAD   = 5'h10
    } op_state_t;

    // Codes carried on the state request port
    typedef enum logic [2:0] {
        REQ_POWERUP   = 3'h1,
        REQ_PRECONFIG = 3'h2,
        REQ_SAFE_RUN  = 3'h4,
        REQ_RUNNING   = 3'h0,
        REQ_FW_LOAD   = 3'h3
    } state_req_t;

endpackage

// *** wd_timer.sv ***
// One watchdog timer counting shared watchdog ticks
module wd_timer
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wdTick,
    input  wire logic        kick,
    input  wire logic [15:0] timeVal,
    output logic             expired_q
);

    logic [15:0] count_q;
    logic        fire;

    // Fires after timeVal ticks without a restart; zero disables
    // A time lowered below the running count fires on the next tick
    assign fire = wdTick && (timeVal != 16'h0000) && !expired_q
                  && (count_q >= timeVal - 16'h0001);

    // Tick counter, restarted by every kick
    always_ff @(posedge clk)
    begin
        if (srst || kick || (timeVal == 16'h0000))
            count_q <= 16'h0000;
        else if (wdTick && !expired_q)
            count_q <= count_q + 16'h0001;
    end

    // Sticky expiry, firing wins over a kick in the same cycle
    always_ff @(posedge clk)
    begin
        if (srst || (timeVal == 16'h0000))
            expired_q <= 1'b0;
        else if (fire)
            expired_q <= 1'b1;
        else if (kick)
            expired_q <= 1'b0;
    end

endmodule

// *** bus_master_model.sv ***
// Behavioural bus master: register access, state requests and process data
module bus_master_model
(
    input  wire logic        clk,
    input  wire logic [15:0] regRdData_q,
    input  wire logic        stateAck_q,
    input  wire logic        stateRefuse_q,
    output logic             regWr,
    output logic             regRd,
    output logic      [15:0] regAddr,
    output logic      [15:0] regWrData,
    output logic             stateReqValid,
    output logic      [2:0]  stateReqCode,
    output logic             pdAccess,
    output logic      [15:0] masterOutData
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle levels at time zero
    initial
    begin
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 16'h0000;
        regWrData = 16'h0000;
        stateReqValid = 1'b0;
        stateReqCode = 3'h0;
        pdAccess = 1'b0;
        masterOutData = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One write strobe cycle; released lines show the inverse value
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        @(negedge clk);
        regWr = 1'b1;
        regAddr = addr;
        regWrData = data;
        @(negedge clk);
        regWr = 1'b0;
        regAddr = ~addr;
        regWrData = ~data;
    endtask

    // One read strobe cycle, data taken the cycle after
    task automatic rd(input logic [15:0] addr, output logic [15:0] data);
        @(negedge clk);
        regRd = 1'b1;
        regAddr = addr;
        @(negedge clk);
        regRd = 1'b0;
        regAddr = ~addr;
        data = regRdData_q;
    endtask

    // Startup download of timing settings, only when selected
    task automatic startup(input bit sel, input logic [15:0] presc, input logic [15:0] lp,
                           input logic [15:0] pd);
        if (sel)
        begin
            wr(16'h0400, presc);
            wr(16'h0410, lp);
            wr(16'h0420, pd);
        end
    endtask

    // State change request, answer pulse taken one cycle later
    task automatic req(input slave_wd_pkg::state_req_t code, output logic ack, output logic rfs);
        @(negedge clk);
        stateReqValid = 1'b1;
        stateReqCode = code;
        @(negedge clk);
        stateReqValid = 1'b0;
        stateReqCode = ~code;
        ack = stateAck_q;
        rfs = stateRefuse_q;
    endtask

    // Present output data
    task automatic put_out(input logic [15:0] data);
        @(negedge clk);
        masterOutData = data;
    endtask

    // Valid output data goes out before the running request
    task automatic go_running(output logic ack, output logic rfs);
        put_out(masterOutData);
        req(slave_wd_pkg::REQ_RUNNING, ack, rfs);
    endtask

    // One process data access pulse
    task automatic pd_kick();
        @(negedge clk);
        pdAccess = 1'b1;
        @(negedge clk);
        pdAccess = 1'b0;
    endtask
endmodule

// *** slave_watchdog_and_state_machine_test.sv ***
// Self-checking bench for the watchdogs and the operating state machine
`include "slave_wd_defines.svh"

module slave_watchdog_and_state_machine_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic localAccess = 1'b0;
    logic mailboxSetupOk = 1'b0;
    logic syncSetupOk = 1'b0;
    logic [15:0] procInData = 16'h0000;
    logic regWr, regRd, stateReqValid, pdAccess;
    logic [15:0] regAddr, regWrData, masterOutData, regRdData, outData, inputSnap;
    logic [2:0] stateReqCode;
    logic inputCopy, stateAck, stateRefuse, mbxAllowed, pdAllowed, fileOnly, pdExp, lpExp;
    logic [4:0] curState;
    int n_mismatch = 0;
    int checks = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Design and far-side master
    slave_watchdog_and_state_machine dut_u
    (
        .clk(clk), .srst(srst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData_q(regRdData), .stateReqValid(stateReqValid),
        .stateReqCode(stateReqCode), .mailboxSetupOk(mailboxSetupOk),
        .syncSetupOk(syncSetupOk), .pdAccess(pdAccess), .localAccess(localAccess),
        .masterOutData(masterOutData), .procInData(procInData), .outData_q(outData),
        .inputSnap_q(inputSnap), .inputCopy_q(inputCopy), .stateAck_q(stateAck),
        .stateRefuse_q(stateRefuse), .curState_q(curState), .mbxAllowed_q(mbxAllowed),
        .pdAllowed_q(pdAllowed), .fileOnly_q(fileOnly), .pdExpired_q(pdExp),
        .lpExpired_q(lpExp)
    );

    bus_master_model mst_u
    (
        .clk(clk), .regRdData_q(regRdData), .stateAck_q(stateAck),
        .stateRefuse_q(stateRefuse), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWrData(regWrData), .stateReqValid(stateReqValid), .stateReqCode(stateReqCode),
        .pdAccess(pdAccess), .masterOutData(masterOutData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for a watchdog flag, counting cycles
    task automatic wait_flag(input bit lp, input int limit, output int n);
        n = 0;
        while (((lp ? lpExp : pdExp) !== 1'b1) && (n < limit))
        begin
            @(negedge clk);
            n++;
        end
        if (n >= limit)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: watchdog flag never rose", $time);
            close_out();
        end
    endtask

    // Request and judge answer and resulting state
    task automatic do_req(input slave_wd_pkg::state_req_t code, input logic ack,
                          input logic [4:0] st);
        logic a;
        logic r;
        mst_u.req(code, a, r);
        chk({14'h0000, a, r}, {14'h0000, ack, ~ack}, "request answer");
        chk({11'h000, curState}, {11'h000, st}, "state after request");
    endtask

    // Local port access pulse
    task automatic lp_kick();
        @(negedge clk);
        localAccess = 1'b1;
        @(negedge clk);
        localAccess = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, download selection and register range
    task automatic t_reset();
        logic [15:0] v;
        chk({11'h000, curState}, 16'h0001, "power-up after reset");
        chk({14'h0000, mbxAllowed, pdAllowed}, 16'h0000, "no traffic");
        mst_u.rd(`REG_PRESCALER, v);
        chk(v, 16'h09C2, "prescaler reset");
        mst_u.rd(`REG_PD_TIME, v);
        chk(v, 16'h03E8, "pd time reset");
        mst_u.rd(16'h0500, v);
        chk(v, 16'h0000, "unmapped read");
        mst_u.startup(1'b0, 16'h0000, 16'h0000, 16'h0000);
        mst_u.rd(`REG_PRESCALER, v);
        chk(v, 16'h09C2, "unselected download");
        mst_u.startup(1'b1, 16'h0000, 16'hFFFF, 16'hFFFF);
        mst_u.rd(`REG_LOCAL_TIME, v);
        chk(v, 16'hFFFF, "timer full range");
        mst_u.rd(`REG_PRESCALER, v);
        chk(v, 16'h0000, "prescaler written");
    endtask

    // Walk the states with refusals on the way
    task automatic t_states();
        logic a;
        logic r;
        do_req(slave_wd_pkg::REQ_PRECONFIG, 1'b0, 5'h01);
        mailboxSetupOk = 1'b1;
        do_req(slave_wd_pkg::REQ_SAFE_RUN, 1'b0, 5'h01);
        do_req(slave_wd_pkg::REQ_PRECONFIG, 1'b1, 5'h02);
        chk({14'h0000, mbxAllowed, pdAllowed}, 16'h0002, "mailbox only");
        do_req(slave_wd_pkg::REQ_FW_LOAD, 1'b0, 5'h02);
        do_req(slave_wd_pkg::REQ_SAFE_RUN, 1'b0, 5'h02);
        mst_u.wr(`REG_SAFE_VALUE, 16'h5A5A);
        procInData = 16'hC3A5;
        syncSetupOk = 1'b1;
        do_req(slave_wd_pkg::REQ_SAFE_RUN, 1'b1, 5'h04);
        chk({15'h0000, inputCopy}, 16'h0001, "input copy pulse");
        chk(inputSnap, 16'hC3A5, "input snapshot");
        chk({14'h0000, mbxAllowed, pdAllowed}, 16'h0003, "all traffic");
        mst_u.put_out(16'h1234);
        repeat (3) @(negedge clk);
        chk(outData, 16'h5A5A, "safe-run outputs");
        mst_u.go_running(a, r);
        chk({15'h0000, a}, 16'h0001, "running accepted");
        chk({11'h000, curState}, 16'h0008, "running");
        repeat (2) @(negedge clk);
        chk(outData, 16'h1234, "running outputs");
        procInData = 16'h0F0F;
        @(negedge clk);
        chk(inputSnap, 16'h0F0F, "cyclic input update");
    endtask

    // Process data watchdog delay, effects and clearing
    task automatic t_pd_wd(input logic [15:0] presc, input logic [15:0] tm);
        int n;
        int p;
        logic [15:0] v;
        p = (int'(presc) + 2) * 8;
        mst_u.wr(`REG_PRESCALER, presc);
        mst_u.wr(`REG_PD_TIME, tm);
        mst_u.pd_kick();
        mst_u.pd_kick();
        wait_flag(1'b0, (int'(tm) + 1) * p + 8, n);
        chk({15'h0000, n >= (int'(tm) - 1) * p && n <= int'(tm) * p + 4}, 16'h0001, "delay");
        chk({11'h000, curState}, 16'h0008, "state kept");
        @(negedge clk);
        chk(outData, 16'h5A5A, "safe on expiry");
        chk({15'h0000, lpExp}, 16'h0000, "local watchdog apart");
        lp_kick();
        repeat (20) @(negedge clk);
        chk({15'h0000, pdExp}, 16'h0001, "expiry sticky");
        mst_u.rd(`REG_STATUS, v);
        chk(v & 16'h0003, 16'h0001, "status flag");
        mst_u.pd_kick();
        chk({15'h0000, pdExp}, 16'h0000, "cleared by access");
        @(negedge clk);
        chk(outData, 16'h1234, "outputs restored");
    endtask

    // Timer value zero disables the process data watchdog
    task automatic t_pd_off();
        mst_u.wr(`REG_PD_TIME, 16'h0000);
        repeat (100) @(negedge clk);
        chk({15'h0000, pdExp}, 16'h0000, "disabled watchdog");
        chk(outData, 16'h1234, "no safe value");
        mst_u.wr(`REG_PD_TIME, 16'hFFFF);
        mst_u.pd_kick();
    endtask

    // Local port watchdog
    task automatic t_lp_wd();
        int n;
        logic [15:0] v;
        mst_u.wr(`REG_PRESCALER, 16'h0000);
        mst_u.wr(`REG_LOCAL_TIME, 16'h0002);
        lp_kick();
        wait_flag(1'b1, 60, n);
        chk({15'h0000, n >= 16 && n <= 36}, 16'h0001, "local delay");
        @(negedge clk);
        chk(outData, 16'h5A5A, "safe on local expiry");
        mst_u.rd(`REG_STATUS, v);
        chk(v & 16'h0003, 16'h0002, "local status flag");
        lp_kick();
        @(negedge clk);
        chk({15'h0000, lpExp}, 16'h0000, "local cleared");
        mst_u.wr(`REG_LOCAL_TIME, 16'hFFFF);
    endtask

    // Firmware-load entry only from power-up
    task automatic t_fw();
        do_req(slave_wd_pkg::REQ_FW_LOAD, 1'b0, 5'h08);
        do_req(slave_wd_pkg::REQ_SAFE_RUN, 1'b1, 5'h04);
        do_req(slave_wd_pkg::REQ_POWERUP, 1'b1, 5'h01);
        do_req(slave_wd_pkg::REQ_FW_LOAD, 1'b1, 5'h10);
        chk({14'h0000, fileOnly, pdAllowed}, 16'h0002, "file transfer only");
        do_req(slave_wd_pkg::REQ_PRECONFIG, 1'b0, 5'h10);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_states();
        t_pd_wd(16'h0000, 16'h0002);
        t_pd_wd(16'h0001, 16'h0003);
        t_pd_wd(16'h0002, 16'h0001);
        t_pd_off();
        t_lp_wd();
        t_fw();
        close_out();
    end
endmodule
